/* File: hw/ipp_consts.svh */
// Constants for the index/data host port: offsets, bit positions, timing
`ifndef IPP_CONSTS_SVH
`define IPP_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define IPP_CLK_MHZ 100
`define IPP_READY_NS 5000
// Least time, rounded up to whole cycles
`define IPP_READY_CYC (((`IPP_READY_NS * `IPP_CLK_MHZ) + 999) / 1000)

// ****************************************
// Host-side register offsets (index space)
// ****************************************
`define IPP_OFF_GPR 8'h1F
`define IPP_OFF_MRD_INC 8'hF2
`define IPP_OFF_MRA_LO 8'hF4
`define IPP_OFF_MRA_HI 8'hF5
`define IPP_OFF_MWR_INC 8'hF8
`define IPP_OFF_MWA_LO 8'hFA
`define IPP_OFF_MWA_HI 8'hFB
`define IPP_GPR_RESET 8'h00
`define IPP_GP_LSB 4
`define IPP_MEM_BYTES 16384
`define IPP_MEM_AW 14

// ****************************************
// Wishbone register byte addresses
// ****************************************
`define IPP_WB_CFG 8'h00
`define IPP_WB_STATUS 8'h04
`define IPP_WB_IRQ_ST 8'h08
`define IPP_WB_IRQ_MASK 8'h0C
`define IPP_WB_GPR 8'h10
`define IPP_CFG_RESET 5'h00

// ****************************************
// Interrupt event bits
// ****************************************
`define IPP_EV_WAKE 0
`define IPP_EV_DWR 1
`define IPP_EV_DRD 2
`define IPP_EV_IDX 3
`define IPP_EV_W 4

// ****************************************
// Upper data pin use in 8-bit mode
// ****************************************
`define IPP_HI_WAKE 7
`define IPP_HI_DUPLEX 6
`define IPP_HI_GPT 5
`define IPP_HI_GPB 3

`endif

/* File: hw/ipp_pkg.sv */
// Types shared by the index/data host port
`default_nettype none
package ipp_pkg;

   // Configuration written through the Wishbone configuration register
   typedef struct packed {
      logic led_mode;
      logic irq_inv;
      logic cs_inv;
      logic wr_inv;
      logic rd_inv;
   } ipp_cfg_t;

   // Levels caught from the strap pins after reset
   typedef struct packed {
      logic bus8;
      logic irq_low;
      logic irq_od;
      logic cs_high;
   } ipp_strap_t;

   // Host control pins
   typedef struct packed {
      logic cs;
      logic cmd;
      logic rd;
      logic wr;
   } ipp_ctl_t;

   // Host cycle state
   typedef enum logic [1:0] {
      IPP_IDLE,
      IPP_READ,
      IPP_WRITE
   } ipp_state_t;

endpackage : ipp_pkg
`default_nettype wire

/* File: hw/ipp_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module ipp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,               // Clock
   input wire logic rst_i,               // Synchronous reset
   input wire logic [WIDTH-1:0] async_i, // Asynchronous levels
   output logic [WIDTH-1:0] sync_o       // Synchronised levels
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage read only by second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule : ipp_sync

`default_nettype wire

/* File: hw/ipp_top.sv */
// Index/data host port with packet memory, straps, indicators and interrupt
//
// How it works
// - Command line high selects data port, low selects index port.
// - Read strobe active low unless configuration inverts it.
// - Write strobe active low unless configuration inverts it.
// - Host cycles answered only while device select is asserted.
// - Interrupt active high by default; configuration or strap inverts it.
// - Data bits 0-7 always; bits 8-15 only in 16-bit mode.
// - Packet memory reachable in 8-bit and 16-bit widths.
// - In 8-bit mode the wake pin asserts on a wake event.
// - Indicator mode 1: drive low at full duplex, float at half.
// - Indicator mode 0: drive low at 10M, float at 100M.
// - In 8-bit mode three general outputs follow register 1Fh.
// - Interrupt open-drain if top general output strapped high, else push-pull.
// - 16K byte packet memory reached through the data port.
// - Memory select strap high gives 8-bit bus, else 16-bit.
// - Memory clock strap high makes interrupt active low.
// - In 8-bit mode wake strap high makes device select active high.
`timescale 1ns/1ps
`default_nettype none
`include "ipp_consts.svh"

module ipp_top
   import ipp_pkg::*;
(
   input wire logic clk_i,                // 100 MHz clock
   input wire logic rst_i,                // Synchronous reset, active high
   // Host pins
   input wire ipp_ctl_t host_ctl_i,       // Select, command, read, write pins
   input wire logic [7:0] host_data_low_i,   // Low data byte in
   output logic [7:0] host_data_low_o,       // Low data byte out
   output logic host_data_low_oe_o,          // Low data byte drive enable
   input wire logic [7:0] host_data_high_i,  // Upper pins in
   output logic [7:0] host_data_high_o,      // Upper pins out
   output logic [7:0] host_data_high_oe_o,   // Upper pins drive enables
   output logic irq_o,                    // Interrupt pin level
   output logic irq_oe_o,                 // Interrupt pin drive enable
   input wire logic rom_select_strap_i,   // Bus width strap pin
   input wire logic rom_clock_strap_i,    // Interrupt polarity strap pin
   // Internal status
   input wire logic phy_full_duplex_i,    // PHY at full duplex
   input wire logic phy_speed_10_i,       // PHY at 10M
   input wire logic wake_event_i,         // Wake-up event pulse
   // Wishbone slave
   input wire logic wb_cyc_i,             // Cycle
   input wire logic wb_stb_i,             // Strobe
   input wire logic wb_we_i,              // Write enable
   input wire logic [7:0] wb_adr_i,       // Byte address
   input wire logic [31:0] wb_dat_i,      // Write data
   input wire logic [3:0] wb_sel_i,       // Byte lanes
   output logic [31:0] wb_dat_o,          // Read data
   output logic wb_ack_o                  // Acknowledge
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   localparam int SW = 22;
   localparam logic [11:0] READY_CYC = 12'(`IPP_READY_CYC);
   localparam int MW = `IPP_MEM_BYTES / 2;

   logic [SW-1:0] pins_s;
   ipp_ctl_t ctl_s;
   logic [7:0] dlo_s;
   logic [7:0] dhi_s;
   logic sel_strap_s;
   logic clk_strap_s;

   ipp_sync #(.WIDTH(SW)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({host_ctl_i, host_data_high_i, host_data_low_i,
                rom_select_strap_i, rom_clock_strap_i}),
      .sync_o(pins_s)
   );

   assign {ctl_s, dhi_s, dlo_s, sel_strap_s, clk_strap_s} = pins_s;

   // ****************************************
   // State
   // ****************************************
   ipp_cfg_t cfg_q;
   ipp_strap_t strap_q;
   ipp_state_t st_q;
   logic ready_q;
   logic [11:0] rdy_cnt_q;
   logic [7:0] index_q;
   logic [7:0] gpr_q;
   logic [`IPP_MEM_AW-1:0] mra_q;
   logic [`IPP_MEM_AW-1:0] mwa_q;
   logic [15:0] rdat_q;
   logic [`IPP_EV_W-1:0] irq_st_q;
   logic [`IPP_EV_W-1:0] irq_mask_q;
   logic [15:0] mem_q [MW];
   logic cs_act;
   logic rd_act;
   logic wr_act;
   logic rd_start;
   logic wr_start;
   logic [15:0] wdat;
   logic [`IPP_MEM_AW-1:0] step;
   logic wb_req;
   logic wb_wr;
   logic [`IPP_EV_W-1:0] ev;
   logic irq_act;

   // Read value of a host-side register
   function automatic logic [15:0] host_reg(input logic [7:0] idx,
                                            input logic [15:0] mword,
                                            input logic lane);
      logic [15:0] v;
      case (idx)
         `IPP_OFF_GPR: v = {8'h00, gpr_q};
         `IPP_OFF_MRA_LO: v = {8'h00, mra_q[7:0]};
         `IPP_OFF_MRA_HI: v = {10'h000, mra_q[13:8]};
         `IPP_OFF_MWA_LO: v = {8'h00, mwa_q[7:0]};
         `IPP_OFF_MWA_HI: v = {10'h000, mwa_q[13:8]};
         `IPP_OFF_MRD_INC: v = strap_q.bus8 ? {8'h00, (lane ? mword[15:8] : mword[7:0])}
                                            : mword;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : host_reg

   // ****************************************
   // Strap capture and ready delay
   // ****************************************
   // Straps caught as the settle delay ends
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdy_cnt_q <= 12'h000;
         ready_q <= 1'b0;
         strap_q <= '0;
      end else if (!ready_q) begin
         rdy_cnt_q <= rdy_cnt_q + 12'h001;
         if (rdy_cnt_q == READY_CYC - 12'h001) begin
            ready_q <= 1'b1;
            strap_q.bus8 <= sel_strap_s;
            strap_q.irq_low <= clk_strap_s;
            strap_q.irq_od <= dhi_s[`IPP_HI_GPT];
            strap_q.cs_high <= sel_strap_s & dhi_s[`IPP_HI_WAKE];
         end
      end
   end

   // ****************************************
   // Host strobe decode
   // ****************************************
   // Pin asserted when its level equals the active level
   assign cs_act = ready_q & (ctl_s.cs == (cfg_q.cs_inv ^ strap_q.cs_high));
   assign rd_act = cs_act & (ctl_s.rd == cfg_q.rd_inv);
   assign wr_act = cs_act & (ctl_s.wr == cfg_q.wr_inv);
   assign rd_start = (st_q == IPP_IDLE) & rd_act & ~wr_act;
   assign wr_start = (st_q == IPP_IDLE) & wr_act & ~rd_act;
   // Upper byte ignored in 8-bit mode
   assign wdat = strap_q.bus8 ? {8'h00, dlo_s} : {dhi_s, dlo_s};
   assign step = strap_q.bus8 ? 14'h0001 : 14'h0002;

   // Host cycle state, one action per strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= IPP_IDLE;
      end else begin
         case (st_q)
            IPP_IDLE: begin
               if (rd_start) begin
                  st_q <= IPP_READ;
               end else if (wr_start) begin
                  st_q <= IPP_WRITE;
               end
            end
            IPP_READ: begin
               if (!rd_act) begin
                  st_q <= IPP_IDLE;
               end
            end
            IPP_WRITE: begin
               if (!wr_act) begin
                  st_q <= IPP_IDLE;
               end
            end
            default: st_q <= IPP_IDLE;
         endcase
      end
   end

   // ****************************************
   // Index, registers and pointers
   // ****************************************
   // Index and data port writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         index_q <= 8'h00;
         gpr_q <= `IPP_GPR_RESET;
         mra_q <= '0;
         mwa_q <= '0;
      end else begin
         if (wr_start && !ctl_s.cmd) begin
            index_q <= dlo_s;
         end else if (wr_start) begin
            case (index_q)
               `IPP_OFF_GPR: gpr_q <= wdat[7:0];
               `IPP_OFF_MRA_LO: mra_q[7:0] <= wdat[7:0];
               `IPP_OFF_MRA_HI: mra_q[13:8] <= wdat[5:0];
               `IPP_OFF_MWA_LO: mwa_q[7:0] <= wdat[7:0];
               `IPP_OFF_MWA_HI: mwa_q[13:8] <= wdat[5:0];
               `IPP_OFF_MWR_INC: mwa_q <= mwa_q + step;
               default: gpr_q <= gpr_q;
            endcase
         end
         if (rd_start && ctl_s.cmd && index_q == `IPP_OFF_MRD_INC) begin
            mra_q <= mra_q + step;
         end
      end
   end

   // Packet memory, byte lanes picked by width
   always_ff @(posedge clk_i) begin
      if (wr_start && ctl_s.cmd && index_q == `IPP_OFF_MWR_INC) begin
         if (!strap_q.bus8) begin
            mem_q[mwa_q[13:1]] <= wdat;
         end else if (mwa_q[0]) begin
            mem_q[mwa_q[13:1]][15:8] <= wdat[7:0];
         end else begin
            mem_q[mwa_q[13:1]][7:0] <= wdat[7:0];
         end
      end
   end

   // Read data caught at read strobe start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 16'h0000;
      end else if (rd_start) begin
         rdat_q <= ctl_s.cmd ? host_reg(index_q, mem_q[mra_q[13:1]], mra_q[0])
                             : {8'h00, index_q};
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
   assign ev[`IPP_EV_WAKE] = wake_event_i;
   assign ev[`IPP_EV_DWR] = wr_start & ctl_s.cmd;
   assign ev[`IPP_EV_DRD] = rd_start & ctl_s.cmd;
   assign ev[`IPP_EV_IDX] = wr_start & ~ctl_s.cmd;
   assign irq_act = |(irq_st_q & irq_mask_q);

   // Sticky status, write one to clear, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_q <= '0;
      end else if (wb_wr && wb_adr_i == `IPP_WB_IRQ_ST) begin
         irq_st_q <= (irq_st_q & ~wb_dat_i[`IPP_EV_W-1:0]) | ev;
      end else begin
         irq_st_q <= irq_st_q | ev;
      end
   end

   // Configuration and mask registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= `IPP_CFG_RESET;
         irq_mask_q <= '0;
      end else if (wb_wr && wb_adr_i == `IPP_WB_CFG) begin
         cfg_q <= wb_dat_i[4:0];
      end else if (wb_wr && wb_adr_i == `IPP_WB_IRQ_MASK) begin
         irq_mask_q <= wb_dat_i[`IPP_EV_W-1:0];
      end
   end

   // Wishbone answer one cycle after the strobe, zero when unmapped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         case (wb_adr_i)
            `IPP_WB_CFG: wb_dat_o <= {27'h0000000, cfg_q};
            `IPP_WB_STATUS: wb_dat_o <= {16'h0000, index_q, 3'h0, ready_q, strap_q};
            `IPP_WB_IRQ_ST: wb_dat_o <= {28'h0000000, irq_st_q};
            `IPP_WB_IRQ_MASK: wb_dat_o <= {28'h0000000, irq_mask_q};
            `IPP_WB_GPR: wb_dat_o <= {24'h000000, gpr_q};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   // Data driven while a read strobe is held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         host_data_low_o <= 8'h00;
         host_data_low_oe_o <= 1'b0;
      end else begin
         host_data_low_o <= rdat_q[7:0];
         host_data_low_oe_o <= (st_q == IPP_READ) & rd_act;
      end
   end

   // Upper pins: data in 16-bit mode, alternate uses in 8-bit mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         host_data_high_o <= 8'h00;
         host_data_high_oe_o <= 8'h00;
      end else if (!ready_q) begin
         host_data_high_o <= 8'h00;
         host_data_high_oe_o <= 8'h00;
      end else if (!strap_q.bus8) begin
         host_data_high_o <= rdat_q[15:8];
         host_data_high_oe_o <= {8{(st_q == IPP_READ) & rd_act}};
      end else begin
         host_data_high_o <= 8'h00;
         host_data_high_oe_o <= 8'h00;
         host_data_high_o[`IPP_HI_WAKE] <= irq_st_q[`IPP_EV_WAKE];
         host_data_high_oe_o[`IPP_HI_WAKE] <= 1'b1;
         host_data_high_oe_o[`IPP_HI_DUPLEX] <= cfg_q.led_mode ? phy_full_duplex_i
                                                               : phy_speed_10_i;
         host_data_high_o[`IPP_HI_GPT:`IPP_HI_GPB] <= gpr_q[`IPP_GP_LSB+2:`IPP_GP_LSB];
         host_data_high_oe_o[`IPP_HI_GPT:`IPP_HI_GPB] <= 3'h7;
      end
   end

   // Interrupt pin: polarity then output type
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         irq_oe_o <= 1'b0;
      end else if (!ready_q) begin
         irq_o <= 1'b0;
         irq_oe_o <= 1'b0;
      end else if (strap_q.irq_od) begin
         irq_o <= 1'b0;
         irq_oe_o <= ~(irq_act ^ cfg_q.irq_inv ^ strap_q.irq_low);
      end else begin
         irq_o <= irq_act ^ cfg_q.irq_inv ^ strap_q.irq_low;
         irq_oe_o <= 1'b1;
      end
   end

endmodule : ipp_top

`default_nettype wire

/* File: verif/ipp_checker.sv */
// Concurrent checks on the ports of the index/data host port
`timescale 1ns/1ps
`default_nettype none

module ipp_checker (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Synchronous reset
   input wire logic [7:0] host_data_low_o, // Low byte out
   input wire logic host_data_low_oe_o, // Low byte enable
   input wire logic [7:0] host_data_high_o, // Upper pins out
   input wire logic [7:0] host_data_high_oe_o, // Upper pin enables
   input wire logic irq_o, // Interrupt level
   input wire logic irq_oe_o, // Interrupt enable
   input wire logic wake_event_i, // Wake event pulse
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic [31:0] wb_dat_o, // Bus read data
   input wire logic wb_ack_o // Bus acknowledge
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Bus answers one cycle after a fresh request, for one cycle only
   a_ack_in_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("Bus request not answered in one cycle");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Acknowledge longer than one cycle");
   a_upper_read_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("Upper read bits not zero");
   // Nothing driven straight after reset
   a_reset_quiet: assert property ($fell(rst_i) |-> !host_data_low_oe_o && !irq_oe_o &&
      host_data_high_oe_o == 8'h00 && !wb_ack_o)
      else $error("Pins driven after reset");
   // Read data stands while driven
   a_read_holds: assert property (host_data_low_oe_o && $past(host_data_low_oe_o) |->
      $stable(host_data_low_o))
      else $error("Read data changed while driven");
   // Upper data pins carry data only together with the low byte
   a_upper_as_data: assert property (host_data_high_oe_o[2:0] != 3'h0 |->
      host_data_high_oe_o == {8{host_data_low_oe_o}})
      else $error("Upper pins driven apart from low byte");
   a_indicator_low: assert property (host_data_high_oe_o[6] && !host_data_low_oe_o |->
      !host_data_high_o[6])
      else $error("Indicator driven high");
   a_irq_drive_od: assert property (irq_o |-> irq_oe_o)
      else $error("Interrupt level high without drive");
   a_wake_pin_set: assert property (wake_event_i && host_data_high_oe_o[7] &&
      host_data_high_oe_o[2:0] == 3'h0 |-> ##[1:3] host_data_high_o[7])
      else $error("Wake pin not raised");

   // Main scenarios reached
   c_bus_ack: cover property (wb_ack_o && wb_cyc_i);
   c_read: cover property ($rose(host_data_low_oe_o));
   c_irq_od: cover property (irq_oe_o && !irq_o);
   c_wake: cover property (host_data_high_o[7] && host_data_high_oe_o[7]);
endmodule : ipp_checker

bind ipp_top ipp_checker ipp_checker_inst (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .host_data_low_o(host_data_low_o),
   .host_data_low_oe_o(host_data_low_oe_o),
   .host_data_high_o(host_data_high_o),
   .host_data_high_oe_o(host_data_high_oe_o),
   .irq_o(irq_o),
   .irq_oe_o(irq_oe_o),
   .wake_event_i(wake_event_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o)
);

`default_nettype wire

/* File: verif/ipp_host_model.sv */
// Host processor model driving the index/data port pins
`timescale 1ns/1ps
`default_nettype none

module ipp_host_model
   import ipp_pkg::*;
(
   input wire logic clk_i, // Clock
   input wire logic [2:0] pol_i, // Active levels: select, read, write
   input wire logic bus16_i, // Host drives upper byte
   input wire logic [7:0] strap_i, // Pull levels of upper pins
   input wire logic [7:0] lo_o_i, // Device low byte out
   input wire logic lo_oe_i, // Device low byte enable
   input wire logic [7:0] hi_o_i, // Device upper pins out
   input wire logic [7:0] hi_oe_i, // Device upper pin enables
   output ipp_ctl_t ctl_o, // Select, command, strobes
   output logic [7:0] lo_o, // Low byte wire level
   output logic [7:0] hi_o // Upper pins wire level
);
   logic a_cs = 1'b0;
   logic a_rd = 1'b0;
   logic a_wr = 1'b0;
   logic cmd_q = 1'b0;
   logic drv = 1'b0;
   logic [15:0] hd = 16'h0000;

   // Pin levels from active flags and chosen polarities
   assign ctl_o = {a_cs ~^ pol_i[2], cmd_q, a_rd ~^ pol_i[1], a_wr ~^ pol_i[0]};
   // Released lines fall to their pull level
   assign lo_o = lo_oe_i ? lo_o_i : (drv ? hd[7:0] : 8'h00);
   assign hi_o = (hi_oe_i & hi_o_i) | (~hi_oe_i & ((drv && bus16_i) ? hd[15:8] : strap_i));

   // One command cycle with setup and hold
   task automatic xfer(input logic w, input logic c, input logic s, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge clk_i);
      a_cs <= s;
      cmd_q <= c;
      drv <= w;
      hd <= d;
      repeat (3) @(posedge clk_i);
      if (w) a_wr <= 1'b1;
      else a_rd <= 1'b1;
      repeat (6) @(posedge clk_i);
      q = {hi_o, lo_o};
      a_rd <= 1'b0;
      a_wr <= 1'b0;
      repeat (4) @(posedge clk_i);
      a_cs <= 1'b0;
      drv <= 1'b0;
      cmd_q <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : xfer
endmodule : ipp_host_model

`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking testbench for the index/data host port
`timescale 1ns/1ps
`default_nettype none
`include "ipp_consts.svh"

module tb_top
   import ipp_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   ipp_ctl_t ctl;
   logic [7:0] lo_i, lo_o, hi_i, hi_o, hi_oe;
   logic [7:0] strap = 8'h00;
   logic rsel = 1'b0, rclk = 1'b0, fd = 1'b0, s10 = 1'b0, wake = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rdat;
   logic [2:0] pol = 3'h0;
   logic lo_oe, irq_o, irq_oe, ack;
   int bad_count = 0, check_count = 0, cycles = 0;
   // Pointers, two data writes, read setup
   localparam logic [16:0] SEQ [2][12] = '{
      '{17'h000FA, 17'h100FC, 17'h000FB, 17'h1003F, 17'h000F8, 17'h1A55A,
        17'h11234, 17'h000F4, 17'h100FC, 17'h000F5, 17'h1003F, 17'h000F2},
      '{17'h000FA, 17'h10001, 17'h000FB, 17'h10000, 17'h000F8, 17'h10011,
        17'h10022, 17'h000F4, 17'h10001, 17'h000F5, 17'h10000, 17'h000F2}};

   ipp_top ipp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .host_ctl_i(ctl),
      .host_data_low_i(lo_i), .host_data_low_o(lo_o), .host_data_low_oe_o(lo_oe),
      .host_data_high_i(hi_i), .host_data_high_o(hi_o), .host_data_high_oe_o(hi_oe),
      .irq_o(irq_o), .irq_oe_o(irq_oe), .rom_select_strap_i(rsel), .rom_clock_strap_i(rclk),
      .phy_full_duplex_i(fd), .phy_speed_10_i(s10), .wake_event_i(wake), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
      .wb_dat_o(rdat), .wb_ack_o(ack));
   ipp_host_model ipp_host_model_inst (.clk_i(clk_i), .pol_i(pol), .bus16_i(~rsel),
      .strap_i(strap), .lo_o_i(lo_o), .lo_oe_i(lo_oe), .hi_o_i(hi_o), .hi_oe_i(hi_oe),
      .ctl_o(ctl), .lo_o(lo_i), .hi_o(hi_i));

   // Clock and hang guard
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         bad_count++;
         give_verdict();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n == 20) bad_count++;
   endtask : wb
   task automatic wbw(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
      repeat (3) @(posedge clk_i);
   endtask : wbw
   task automatic wbc(input string nm, input logic [7:0] a, input logic [15:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, q[15:0], e);
   endtask : wbc
   task automatic hw(input logic c, input logic [15:0] d);
      logic [15:0] q;
      ipp_host_model_inst.xfer(1'b1, c, 1'b1, d, q);
   endtask : hw
   task automatic hc(input string nm, input logic c, input logic [15:0] m, input logic [15:0] e);
      logic [15:0] q;
      ipp_host_model_inst.xfer(1'b0, c, 1'b1, 16'h0000, q);
      chk(nm, q & m, e);
   endtask : hc
   task automatic pulse_wake();
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pulse_wake
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_boot();
      wbc("early status", `IPP_WB_STATUS, 16'h0000);
      hw(1'b0, 16'h00F4);
      repeat (`IPP_READY_CYC) @(posedge clk_i);
      wbc("status", `IPP_WB_STATUS, 16'h0010);
      wbc("cfg", `IPP_WB_CFG, 16'h0000);
      wbc("mask", `IPP_WB_IRQ_MASK, 16'h0000);
      wbc("gpr", `IPP_WB_GPR, 16'h0000);
      wbw(8'h40, 32'hFF);
      wbc("unmapped", 8'h40, 16'h0000);
      hc("early index", 1'b0, 16'hFFFF, 16'h0000);
      $display("boot test done");
   endtask : t_boot
   task automatic t_mem(input int k, input logic [15:0] m, input logic [15:0] e0,
                        input logic [15:0] e1);
      for (int i = 0; i < 12; i++) hw(SEQ[k][i][16], SEQ[k][i][15:0]);
      hc("mem first", 1'b1, m, e0);
      hc("mem second", 1'b1, m, e1);
      hc("index back", 1'b0, m, 16'h00F2);
      $display("memory test done");
   endtask : t_mem
   task automatic t_pol();
      logic [15:0] q;
      wbw(`IPP_WB_CFG, 32'h7);
      pol <= 3'h7;
      hw(1'b0, 16'h001F);
      hc("inverted index", 1'b0, 16'hFFFF, 16'h001F);
      ipp_host_model_inst.xfer(1'b1, 1'b0, 1'b0, 16'h00F4, q);
      hc("deselected", 1'b0, 16'hFFFF, 16'h001F);
      wbw(`IPP_WB_CFG, 32'h0);
      pol <= 3'h0;
      $display("polarity test done");
   endtask : t_pol
   task automatic t_irq();
      wbw(`IPP_WB_IRQ_ST, 32'h1F);
      hw(1'b0, 16'h00F2);
      wbc("index event", `IPP_WB_IRQ_ST, 16'h0008);
      chk("irq masked", 16'({irq_o, irq_oe}), 16'h1);
      wbw(`IPP_WB_IRQ_MASK, 32'h8);
      chk("irq active", 16'({irq_o, irq_oe}), 16'h3);
      wbw(`IPP_WB_CFG, 32'h8);
      chk("irq inverted", 16'({irq_o, irq_oe}), 16'h1);
      pulse_wake();
      wbc("wake event", `IPP_WB_IRQ_ST, 16'h0009);
      wbw(`IPP_WB_IRQ_ST, 32'hF);
      wbc("cleared", `IPP_WB_IRQ_ST, 16'h0000);
      chk("irq idle inv", 16'({irq_o, irq_oe}), 16'h3);
      wbw(`IPP_WB_CFG, 32'h0);
      wbw(`IPP_WB_IRQ_MASK, 32'h0);
      $display("interrupt test done");
   endtask : t_irq
   task automatic t_bus8();
      strap <= 8'hA0;
      rsel <= 1'b1;
      rclk <= 1'b1;
      pol <= 3'h4;
      do_reset();
      repeat (`IPP_READY_CYC + 5) @(posedge clk_i);
      wbc("status 8-bit", `IPP_WB_STATUS, 16'h001F);
      chk("irq od idle", 16'({irq_o, irq_oe}), 16'h0);
      hw(1'b0, 16'h001F);
      hw(1'b1, 16'h0070);
      wbc("gpr set", `IPP_WB_GPR, 16'h0070);
      chk("gp pins", 16'({hi_o[5:3], hi_oe[5:3]}), 16'h3F);
      hw(1'b1, 16'h0050);
      chk("gp pins mixed", 16'({hi_o[5:3], hi_oe[5:3]}), 16'h2F);
      fd <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("led 100M", 16'(hi_oe[6]), 16'h0);
      s10 <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("led 10M", 16'({hi_o[6], hi_oe[6]}), 16'h1);
      wbw(`IPP_WB_CFG, 32'h10);
      chk("led full", 16'({hi_o[6], hi_oe[6]}), 16'h1);
      fd <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("led half", 16'(hi_oe[6]), 16'h0);
      pulse_wake();
      chk("wake pin", 16'({hi_o[7], hi_oe[7]}), 16'h3);
      wbw(`IPP_WB_IRQ_MASK, 32'h1);
      chk("irq od on", 16'({irq_o, irq_oe}), 16'h1);
      wbw(`IPP_WB_IRQ_ST, 32'h1);
      chk("wake cleared", 16'({hi_o[7], irq_oe}), 16'h0);
      t_mem(1, 16'h00FF, 16'h0011, 16'h0022);
      $display("8-bit test done");
   endtask : t_bus8

   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   // Main sequence
   initial begin
      do_reset();
      t_boot();
      t_mem(0, 16'hFFFF, 16'hA55A, 16'h1234);
      t_pol();
      t_irq();
      t_bus8();
      give_verdict();
   end
endmodule : tb_top

`default_nettype wire
